// ### verilog/focr_regs.v
// Purpose: APB register bank for identification, period, control, status
// Assumes: one 25 MHz clock pclk, async active-low presetn
// Notes:   status inputs from the core arrive asynchronous and are synced
//
// Contract
// [R1] ident register read-only, four byte fields
// [R2] period register low twelve bits, rest zero
// [R3] zero commands start on written rising edge
// [R4] error clear bit resets latched errors
// [R5] link bits steer speed and current loops
// [R6] index match selects and interpolator enable
// [R7] angle reset bits hold evaluators in reset
// [R8] inhibit bit bypasses scalar filter
// [R9] default angle source selected by bit
// [R10] feedback ignore bit controls current regulator
// [R11] motor type bit: three-phase or stepper
// [R12] modulation levels field selects two or three
// [R13] rotor angle source field, seven codes
// [R14] modulator request field, in-use status bit
// [R15] coil enable gates drive outputs, else low
// [R16] status read freezes snapshot atomically
// [R17] kill and failure inputs reported read-only
// [R18] per-phase, link overcurrent and system error
// [R19] modulation zone two-bit status field
// [R20] speed direction and moving status bits
// [R21] pwm overflow status bit
// [R22] overflow sticks until coil enable written zero
// [R23] current over limit trips and neutralises coils
`timescale 1ns/10ps
`default_nettype none
`include "focr_defs.vh"

module focr_regs (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [11:0] loop_period_in,
    input  wire        gate_kill_in,
    input  wire        gate_fail_in,
    input  wire [3:0]  overcurrent_in,
    input  wire        sys_error_in,
    input  wire [1:0]  mod_zone_in,
    input  wire        modulator_in_use_in,
    input  wire        speed_fwd_in,
    input  wire        speed_moving_in,
    input  wire        pwm_overflow_in,
    input  wire [16:0] stator_current_in,
    input  wire [5:0]  coil_drive_in,
    output reg  [5:0]  coil_drive_out,
    output reg         coil_neutral,
    output reg         zero_vphase_start,
    output reg         zero_vlink_start,
    output reg         zero_current_start,
    output reg         error_clear,
    output reg         scalar_to_speed_link,
    output reg         speed_to_current_link,
    output reg         enc_match_a,
    output reg         enc_match_b,
    output reg         enc_match_index,
    output reg         enc_interp_en,
    output reg         enc_angle_reset,
    output reg         emu_angle_reset,
    output reg         obs_angle_reset,
    output reg         scalar_filter_bypass,
    output reg         default_angle_fbk,
    output reg         current_feedback_ignore,
    output reg         three_phase_select,
    output reg  [1:0]  mod_levels,
    output reg  [3:0]  rotor_src,
    output reg  [1:0]  modulator_request
);

// -----------------------------------------------------------------
// bus decode
// -----------------------------------------------------------------
wire        setup_wr;
wire        setup_rd;
wire        hit_ctl;
wire        hit_lim;
wire        hit_sta;
wire        mapped;

// zero-wait slave: answer in the cycle after setup
// writes land at the setup edge; an apb transfer cannot be aborted,
// so the early commit is never undone by the master
assign setup_wr = psel & ~penable & pwrite;
assign setup_rd = psel & ~penable & ~pwrite;
assign hit_ctl  = (paddr == `FOCR_OFS_CONTROL);
assign hit_lim  = (paddr == `FOCR_OFS_STIM_LIMIT);
assign hit_sta  = (paddr == `FOCR_OFS_STATUS);
assign mapped   = (paddr == `FOCR_OFS_IDENT) | (paddr == `FOCR_OFS_PERIOD)
                | hit_ctl | hit_sta | hit_lim;

// -----------------------------------------------------------------
// synchronised core status
// -----------------------------------------------------------------
wire [11:0] period_s;
// flag vector layout after the synchroniser:
//   [18:13] coil drive pattern from the core
//   [12] kill, [11] hardware failure
//   [10:7] overcurrent phase a, b, c, then link
//   [6] system error, [5:4] modulation zone
//   [3] modulator in use, [2] forward, [1] moving
//   [0] pwm overflow
wire [18:0] flags_s;
wire [16:0] ismag_s;

focr_sync3 #(.W(12)) u_sync_period (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (loop_period_in),
    .sync_out (period_s)
);

// limitation: bits are filtered one by one, so a multi-bit change
// may show a mixed word for a cycle
focr_sync3 #(.W(19)) u_sync_flags (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({coil_drive_in,
                gate_kill_in, gate_fail_in, overcurrent_in,
                sys_error_in, mod_zone_in, modulator_in_use_in,
                speed_fwd_in, speed_moving_in, pwm_overflow_in}),
    .sync_out (flags_s)
);

focr_sync3 #(.W(17)) u_sync_ismag (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (stator_current_in),
    .sync_out (ismag_s)
);

// -----------------------------------------------------------------
// control and limit registers
// -----------------------------------------------------------------
reg  [31:0] ctrl_q;
reg  [16:0] limit_q;
reg         isovf_q;
wire        ctl_wr;
wire [31:0] ctrl_d;
wire        trip_now;

assign ctl_wr = setup_wr & hit_ctl;
assign ctrl_d = pwdata & `FOCR_CTRL_MASK;
// comparison uses synced magnitude; limit zero disables the trip
assign trip_now = (limit_q != `FOCR_LIMIT_RST) & (ismag_s > limit_q);

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ctrl_q  <= `FOCR_CTRL_RST;
        limit_q <= `FOCR_LIMIT_RST;
    end else begin
        if (ctl_wr) begin
            ctrl_q <= ctrl_d;
        end else if (trip_now) begin
            // [R23] stop on overflow
            ctrl_q[`FOCR_C_COIL] <= 1'b0;
        end
        if (setup_wr & hit_lim) begin
            limit_q <= pwdata[`FOCR_LIMIT_W-1:0];
        end
    end
end

// -----------------------------------------------------------------
// stator current overflow latch
// -----------------------------------------------------------------
// set wins over clear so a trip during the clearing write is kept
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        isovf_q <= 1'b0;
    end else begin
        // [R23] set on overflow
        if (trip_now) begin
            isovf_q <= 1'b1;
        // [R22] clear via coil off
        end else if (ctl_wr & ~pwdata[`FOCR_C_COIL]) begin
            isovf_q <= 1'b0;
        end
    end
end

// written 0-to-1 transition of one control bit
function rise_cmd;
    input        wr_now;
    input [31:0] wdat;
    input [31:0] old;
    input integer pos;
    begin
        rise_cmd = wr_now & wdat[pos] & ~old[pos];
    end
endfunction

// -----------------------------------------------------------------
// command pulses and control outputs
// -----------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        zero_vphase_start       <= 1'b0;
        zero_vlink_start        <= 1'b0;
        zero_current_start      <= 1'b0;
        error_clear             <= 1'b0;
        scalar_to_speed_link    <= 1'b0;
        speed_to_current_link   <= 1'b0;
        enc_match_a             <= 1'b0;
        enc_match_b             <= 1'b0;
        enc_match_index         <= 1'b0;
        enc_interp_en           <= 1'b0;
        enc_angle_reset         <= 1'b0;
        emu_angle_reset         <= 1'b0;
        obs_angle_reset         <= 1'b0;
        scalar_filter_bypass    <= 1'b0;
        default_angle_fbk       <= 1'b0;
        current_feedback_ignore <= 1'b0;
        three_phase_select      <= 1'b0;
        mod_levels              <= 2'b00;
        rotor_src               <= 4'h0;
        modulator_request       <= 2'b00;
    end else begin
        // [R3] rising edge only
        zero_vphase_start  <= rise_cmd(ctl_wr, pwdata, ctrl_q, `FOCR_C_ZVPH);
        zero_vlink_start   <= rise_cmd(ctl_wr, pwdata, ctrl_q, `FOCR_C_ZVBUS);
        zero_current_start <= rise_cmd(ctl_wr, pwdata, ctrl_q, `FOCR_C_ZCUR);
        // [R4] clear latched errors
        error_clear        <= ctl_wr & pwdata[`FOCR_C_ERRCLR];
        // [R5] loop linking
        scalar_to_speed_link  <= ctrl_q[`FOCR_C_S2SPD];
        speed_to_current_link <= ctrl_q[`FOCR_C_SPD2CUR];
        // [R6] index match selects
        enc_match_a     <= ctrl_q[`FOCR_C_ENCA];
        enc_match_b     <= ctrl_q[`FOCR_C_ENCA-1];
        enc_match_index <= ctrl_q[`FOCR_C_ENCI];
        enc_interp_en   <= ctrl_q[`FOCR_C_INTERP];
        // [R7] angle reset locks
        enc_angle_reset <= ctrl_q[`FOCR_C_ENCRST];
        emu_angle_reset <= ctrl_q[`FOCR_C_EMURST];
        obs_angle_reset <= ctrl_q[`FOCR_C_OBSRST];
        // [R8] filter bypass
        scalar_filter_bypass    <= ctrl_q[`FOCR_C_SCINH];
        // [R9] default angle source
        default_angle_fbk       <= ctrl_q[`FOCR_C_ANGDEF];
        // [R10] feedback ignore
        current_feedback_ignore <= ctrl_q[`FOCR_C_FBIGN];
        // [R11] motor type
        three_phase_select      <= ctrl_q[`FOCR_C_3PH];
        // [R12] modulation levels
        mod_levels <= ctrl_q[`FOCR_C_LVL_LO+1:`FOCR_C_LVL_LO];
        // [R13] rotor angle source
        rotor_src  <= ctrl_q[`FOCR_C_SRC_LO+3:`FOCR_C_SRC_LO];
        // [R14] modulator request
        modulator_request <= ctrl_q[`FOCR_C_MOD_LO+1:`FOCR_C_MOD_LO];
    end
end

// -----------------------------------------------------------------
// coil drive gating
// -----------------------------------------------------------------
// a trip forces neutral at once, without waiting for the control copy
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        coil_drive_out <= 6'h00;
        coil_neutral   <= 1'b1;
    end else begin
        // [R15] gate coil outputs
        if (ctrl_q[`FOCR_C_COIL] & ~trip_now & ~isovf_q) begin
            coil_drive_out <= flags_s[18:13];
            coil_neutral   <= 1'b0;
        end else begin
            // [R23] coils to neutral
            coil_drive_out <= 6'h00;
            coil_neutral   <= 1'b1;
        end
    end
end

// -----------------------------------------------------------------
// status word
// -----------------------------------------------------------------
reg  [31:0] status_live;

always @* begin
    status_live = 32'h00000000;
    // [R17] gate unit inputs
    status_live[`FOCR_S_KILL] = flags_s[12];
    status_live[`FOCR_S_FAIL] = flags_s[11];
    // [R18] overcurrent and system error
    status_live[`FOCR_S_OVA:`FOCR_S_OVA-3] = flags_s[10:7];
    status_live[`FOCR_S_SYSERR] = flags_s[6];
    // [R19] modulation zone
    status_live[`FOCR_S_ZONE_LO+1:`FOCR_S_ZONE_LO] = flags_s[5:4];
    // [R14] modulator in use
    status_live[`FOCR_S_MODUSE] = flags_s[3];
    // [R20] direction and moving
    status_live[`FOCR_S_FWD]    = flags_s[2];
    status_live[`FOCR_S_MOVING] = flags_s[1];
    // [R21] pwm overflow
    status_live[`FOCR_S_PWMOVF] = flags_s[0];
    status_live[`FOCR_S_ISOVF]  = isovf_q;
end

// -----------------------------------------------------------------
// read path
// -----------------------------------------------------------------
reg [31:0] rd_d;

always @* begin
    case (paddr)
        // [R1] identification bytes
        `FOCR_OFS_IDENT:
            rd_d = {`FOCR_ID_CODE, `FOCR_ID_MAJOR,
                    `FOCR_ID_MINOR, `FOCR_ID_COMPAT};
        // [R2] period, upper zero
        `FOCR_OFS_PERIOD:     rd_d = {20'h00000, period_s};
        `FOCR_OFS_CONTROL:    rd_d = ctrl_q;
        // [R16] snapshot taken at setup
        `FOCR_OFS_STATUS:     rd_d = status_live;
        `FOCR_OFS_STIM_LIMIT: rd_d = {15'h0000, limit_q};
        default:              rd_d = 32'h00000000;
    endcase
end

// the whole word is captured in one edge; a multi-bit field still passing the bitwise synchroniser may read mixed
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata  <= 32'h00000000;
        pready  <= 1'b0;
        pslverr <= 1'b0;
    end else begin
        pready  <= psel & ~penable;
        pslverr <= psel & ~penable & ~mapped;
        if (setup_rd) begin
            prdata <= rd_d;
        end
    end
end

endmodule // focr_regs
`default_nettype wire

// ### shared/focr_defs.vh
// Purpose: constants for the drive control/status register bank
// Assumes: 32-bit APB, word-aligned registers
// Notes:   offsets are byte addresses
`ifndef FOCR_DEFS_VH
`define FOCR_DEFS_VH

// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define FOCR_OFS_IDENT      12'h000
`define FOCR_OFS_PERIOD     12'h004
`define FOCR_OFS_CONTROL    12'h008
`define FOCR_OFS_STATUS     12'h00c
`define FOCR_OFS_STIM_LIMIT 12'h010

// -----------------------------------------------------------------
// identification fields (values arbitrary, not a real part)
// -----------------------------------------------------------------
`define FOCR_ID_CODE   8'h5a
`define FOCR_ID_MAJOR  8'h03
`define FOCR_ID_MINOR  8'h04
`define FOCR_ID_COMPAT 8'h11

// -----------------------------------------------------------------
// control bit positions
// -----------------------------------------------------------------
`define FOCR_C_ZVPH     26
`define FOCR_C_ZVBUS    25
`define FOCR_C_ERRCLR   24
`define FOCR_C_ZCUR     23
`define FOCR_C_S2SPD    22
`define FOCR_C_SPD2CUR  21
`define FOCR_C_ENCA     20
`define FOCR_C_ENCI     18
`define FOCR_C_INTERP   17
`define FOCR_C_ENCRST   16
`define FOCR_C_SCINH    15
`define FOCR_C_EMURST   14
`define FOCR_C_OBSRST   13
`define FOCR_C_ANGDEF   12
`define FOCR_C_FBIGN    11
`define FOCR_C_3PH      10
`define FOCR_C_LVL_LO   8
`define FOCR_C_SRC_LO   4
`define FOCR_C_MOD_LO   2
`define FOCR_C_COIL     0
`define FOCR_CTRL_MASK  32'h07fffffd
`define FOCR_CTRL_RST   32'h00000000

// -----------------------------------------------------------------
// status bit positions
// -----------------------------------------------------------------
`define FOCR_S_KILL     16
`define FOCR_S_FAIL     15
`define FOCR_S_OVA      14
`define FOCR_S_SYSERR   10
`define FOCR_S_ZONE_LO  5
`define FOCR_S_MODUSE   4
`define FOCR_S_FWD      3
`define FOCR_S_MOVING   2
`define FOCR_S_PWMOVF   1
`define FOCR_S_ISOVF    0

// -----------------------------------------------------------------
// misc
// -----------------------------------------------------------------
`define FOCR_PERIOD_W   12
`define FOCR_LIMIT_W    17
`define FOCR_LIMIT_RST  17'h00000

`endif

// ### verilog/focr_sync3.v
// Purpose: three-stage synchroniser with agreement filter, vector wide
// Assumes: inputs asynchronous to pclk
// Notes:   output changes when stages two and three agree
`timescale 1ns/10ps
`default_nettype none

module focr_sync3 #(
    parameter W = 8
) (
    input  wire         pclk,
    input  wire         presetn,
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);

// -----------------------------------------------------------------
// synchroniser stages
// -----------------------------------------------------------------
reg [W-1:0] s1_q;
reg [W-1:0] s2_q;
reg [W-1:0] s3_q;

// stage one feeds only stage two, bitwise agreement filter at the end
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        s1_q     <= {W{1'b0}};
        s2_q     <= {W{1'b0}};
        s3_q     <= {W{1'b0}};
        sync_out <= {W{1'b0}};
    end else begin
        s1_q     <= async_in;
        s2_q     <= s1_q;
        s3_q     <= s2_q;
        sync_out <= (s2_q & s3_q) | (sync_out & (s2_q | s3_q));
    end
end

endmodule // focr_sync3
`default_nettype wire

// ### test/focr_regs_chk.sv
// Purpose: port assertions for the drive register bank
// Assumes: single pclk domain, async active-low presetn
// Notes:   bound to focr_regs from the testbench top file
`timescale 1ns/10ps
`default_nettype none
`include "focr_defs.vh"

module focr_regs_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [5:0]  coil_drive_out,
    input wire logic        coil_neutral,
    input wire logic        zero_vphase_start,
    input wire logic        zero_current_start,
    input wire logic        error_clear,
    input wire logic [1:0]  mod_levels,
    input wire logic [3:0]  rotor_src
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // -------------------------------------------------------------
    // decoded request phases
    // -------------------------------------------------------------
    wire logic setup = psel && !penable;
    wire logic wr_ctl = setup && pwrite && paddr == `FOCR_OFS_CONTROL;

    // -------------------------------------------------------------
    // bus timing and register contents
    // -------------------------------------------------------------
    property p_rdy; setup |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready after setup");
    property p_acc; pready |-> psel && penable; endproperty
    a_acc: assert property (p_acc) else $error("ready outside access");
    property p_err; setup && paddr > 12'h010 |=> pready && pslverr;
    endproperty
    a_err: assert property (p_err) else $error("unmapped not refused");
    property p_id; setup && !pwrite && paddr == `FOCR_OFS_IDENT |=>
        prdata == {`FOCR_ID_CODE, `FOCR_ID_MAJOR, `FOCR_ID_MINOR,
                   `FOCR_ID_COMPAT}; endproperty
    a_id: assert property (p_id) else $error("ident word wrong");
    property p_per; setup && !pwrite && paddr == `FOCR_OFS_PERIOD |=>
        prdata[31:12] == 20'h00000; endproperty
    a_per: assert property (p_per) else $error("period upper set");
    property p_src; wr_ctl |-> ##2 rotor_src == $past(pwdata[7:4], 2);
    endproperty
    a_src: assert property (p_src) else $error("rotor source");
    property p_lvl; wr_ctl |-> ##2 mod_levels == $past(pwdata[9:8], 2);
    endproperty
    a_lvl: assert property (p_lvl) else $error("mod levels");
    property p_zc; zero_current_start |-> $past(wr_ctl, 1); endproperty
    a_zc: assert property (p_zc) else $error("stray zero cmd");
    property p_zv; zero_vphase_start |=> !zero_vphase_start; endproperty
    a_zv: assert property (p_zv) else $error("zero cmd too long");
    property p_clr; error_clear |-> $past(wr_ctl && pwdata[24], 1);
    endproperty
    a_clr: assert property (p_clr) else $error("stray clear");
    property p_coil; coil_neutral |-> coil_drive_out == 6'h00; endproperty
    a_coil: assert property (p_coil) else $error("coils driven");
endmodule // focr_regs_chk

`default_nettype wire

// ### test/testbench.sv
// Purpose: self-checking bench for the drive register bank
// Assumes: APB master in this file, inputs driven at rising edge
// Notes:   status inputs pass a synchroniser, so reads wait 8 cycles
`timescale 1ns/10ps
`default_nettype none
`include "focr_defs.vh"

module testbench;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0, loop_period_in = 0;
    logic [31:0] pwdata = 0, q, r, seed = 32'd28228;
    logic        e, gate_kill_in = 0, gate_fail_in = 0, sys_error_in = 0;
    logic        modulator_in_use_in = 0, speed_fwd_in = 0;
    logic        speed_moving_in = 0, pwm_overflow_in = 0;
    logic [3:0]  overcurrent_in = 0;
    logic [1:0]  mod_zone_in = 0;
    logic [16:0] stator_current_in = 0;
    logic [5:0]  coil_drive_in = 0;
    wire logic [31:0] prdata;
    wire logic [5:0]  coil_drive_out;
    wire logic [3:0]  rotor_src;
    wire logic [1:0]  mod_levels, modulator_request;
    wire logic pready, pslverr, coil_neutral, zvp, zvl, zcu, error_clear;
    wire logic s2s, s2c, ema, emb, emi, eie, ear, mar, oar, sfb, daf, cfi;
    wire logic three_phase_select;
    int err_total = 0, n_checks = 0, cyc = 0, i;

    focr_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .loop_period_in(loop_period_in), .gate_kill_in(gate_kill_in),
        .gate_fail_in(gate_fail_in), .overcurrent_in(overcurrent_in),
        .sys_error_in(sys_error_in), .mod_zone_in(mod_zone_in),
        .modulator_in_use_in(modulator_in_use_in),
        .speed_fwd_in(speed_fwd_in), .speed_moving_in(speed_moving_in),
        .pwm_overflow_in(pwm_overflow_in),
        .stator_current_in(stator_current_in),
        .coil_drive_in(coil_drive_in), .coil_drive_out(coil_drive_out),
        .coil_neutral(coil_neutral), .zero_vphase_start(zvp),
        .zero_vlink_start(zvl), .zero_current_start(zcu),
        .error_clear(error_clear), .scalar_to_speed_link(s2s),
        .speed_to_current_link(s2c), .enc_match_a(ema), .enc_match_b(emb),
        .enc_match_index(emi), .enc_interp_en(eie), .enc_angle_reset(ear),
        .emu_angle_reset(mar), .obs_angle_reset(oar),
        .scalar_filter_bypass(sfb), .default_angle_fbk(daf),
        .current_feedback_ignore(cfi),
        .three_phase_select(three_phase_select), .mod_levels(mod_levels),
        .rotor_src(rotor_src), .modulator_request(modulator_request));

    // -------------------------------------------------------------
    // clock and hang guard
    // -------------------------------------------------------------
    always #20 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            final_report();
        end
    end

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // status word as the inputs should show it
    function automatic logic [31:0] st_exp(input logic ov);
        return {15'h0, gate_kill_in, gate_fail_in, overcurrent_in,
                sys_error_in, 3'h0, mod_zone_in, modulator_in_use_in,
                speed_fwd_in, speed_moving_in, pwm_overflow_in, ov};
    endfunction

    task automatic chk(input string nm, input logic [31:0] s, x);
        n_checks++;
        if (s !== x) begin
            $display("[ERR] %s expected %h seen %h", nm, x, s);
            err_total++;
        end
    endtask

    // one apb transfer, holds the request until pready is sampled
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) err_total++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        // writes to the ident word must not stick
        apb(1, `FOCR_OFS_IDENT, rnd());
        apb(0, `FOCR_OFS_IDENT, 0);
        chk("ident", q, {`FOCR_ID_CODE, `FOCR_ID_MAJOR, `FOCR_ID_MINOR,
            `FOCR_ID_COMPAT});
        r = rnd();
        loop_period_in <= r[11:0];
        repeat (8) @(posedge pclk);
        apb(0, `FOCR_OFS_PERIOD, 0);
        chk("period", q, {20'h0, r[11:0]});
        // all-ones corner, then random control words
        for (i = 0; i < 10; i++) begin
            r = (i == 0) ? 32'hffffffff : rnd();
            apb(1, `FOCR_OFS_CONTROL, r);
            #1;
            chk("ctrl out", {11'h0, s2s, s2c, ema, emb, emi, eie, ear, sfb,
                mar, oar, daf, cfi, three_phase_select, mod_levels,
                rotor_src, modulator_request}, {11'h0, r[22:2]});
            apb(0, `FOCR_OFS_CONTROL, 0);
            chk("ctrl rd", q, r & `FOCR_CTRL_MASK);
        end
        // commands fire on a written rise, clear on every write of one
        apb(1, `FOCR_OFS_CONTROL, 0);
        apb(1, `FOCR_OFS_CONTROL, 32'h07800000);
        // pulses stand from the setup edge to the sampling edge
        chk("cmd go", {28'h0, zvp, zvl, zcu, error_clear}, 32'hf);
        apb(1, `FOCR_OFS_CONTROL, 32'h07800000);
        chk("cmd hold", {28'h0, zvp, zvl, zcu, error_clear}, 32'h1);
        // status flags follow the gate and loop inputs
        for (i = 0; i < 6; i++) begin
            r = rnd();
            {gate_kill_in, gate_fail_in, overcurrent_in, sys_error_in,
             mod_zone_in, modulator_in_use_in, speed_fwd_in,
             speed_moving_in, pwm_overflow_in} <= r[12:0];
            repeat (8) @(posedge pclk);
            apb(0, `FOCR_OFS_STATUS, 0);
            chk("status", q, st_exp(1'b0));
        end
        // coil drive passes when enabled, trips on current over limit
        apb(1, `FOCR_OFS_STIM_LIMIT, 32'h1000);
        r = rnd();
        coil_drive_in <= r[5:0];
        apb(1, `FOCR_OFS_CONTROL, 32'h1);
        repeat (8) @(posedge pclk);
        chk("coil on", {25'h0, coil_neutral, coil_drive_out},
            {26'h0, r[5:0]});
        stator_current_in <= 17'h01001;
        repeat (8) @(posedge pclk);
        apb(0, `FOCR_OFS_STATUS, 0);
        chk("trip", q, st_exp(1'b1));
        chk("neutral", {25'h0, coil_neutral, coil_drive_out}, 32'h40);
        stator_current_in <= 17'h00000;
        // let the synchronised magnitude fall, else the trip wins
        repeat (8) @(posedge pclk);
        apb(1, `FOCR_OFS_CONTROL, 0);
        repeat (2) @(posedge pclk);
        apb(0, `FOCR_OFS_STATUS, 0);
        chk("trip clr", q, st_exp(1'b0));
        // an unmapped word is refused and reads zero
        apb(0, 12'h020, 0);
        chk("unmapped", q, 32'h0);
        chk("slverr", {31'h0, e}, 32'h1);
        final_report();
    end
endmodule // testbench

bind focr_regs focr_regs_chk u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .coil_drive_out(coil_drive_out), .coil_neutral(coil_neutral),
    .zero_vphase_start(zero_vphase_start),
    .zero_current_start(zero_current_start), .error_clear(error_clear),
    .mod_levels(mod_levels), .rotor_src(rotor_src));

`default_nettype wire
